// File: logic/swd_cfg.svh
// constants for the supervisor timer
`ifndef SWD_CFG_SVH
`define SWD_CFG_SVH
`define SWD_CTRL_ADDR 8'h0D
`define SWD_CTRL_RESET 8'h7F
`define SWD_ACT_BIT 7
`define SWD_TOP_BIT 6
`define SWD_TICK_CYCLES 65536
`define SWD_WAKE_CYCLES 514
`define SWD_RST_PULSE_NS 500
`define SWD_CLK_PERIOD_NS 10
`define SWD_RST_PULSE_CYCLES ((`SWD_RST_PULSE_NS + `SWD_CLK_PERIOD_NS - 1) / `SWD_CLK_PERIOD_NS)
`endif

// File: logic/swd_divider.sv
// cycle divider that gives a one-cycle tick
`timescale 1ns/100ps
module swd_divider #(
  parameter int unsigned DIV = 65536
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  output logic tick
);
  localparam int W = $clog2(DIV);
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= '0;
    end else if (run) begin
      if (cnt_r == W'(DIV - 1)) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + W'(1);
      end
    end
  end

  assign tick = run && (cnt_r == W'(DIV - 1));
endmodule

// File: logic/swd_pkg.sv
// types for the supervisor timer
package swd_pkg;
  typedef enum logic [2:0] {
    SWD_RUN = 3'b001,
    SWD_HALTED = 3'b010,
    SWD_WAKE = 3'b100
  } swd_state_t;
endpackage

// File: logic/swd_timer.sv
// supervisor timer with activate bit, 7-bit down count and reset pulse
`timescale 1ns/100ps
`include "swd_cfg.svh"
module swd_timer #(
  parameter int unsigned TICK_CYCLES = `SWD_TICK_CYCLES,
  parameter int unsigned WAKE_CYCLES = `SWD_WAKE_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic hw_watchdog_option,
  input wire logic ctrl_write,
  input wire logic [7:0] ctrl_wdata,
  output logic [7:0] watchdog_control,
  input wire logic halt_enter,
  input wire logic ext_wakeup,
  input wire logic wait_mode,
  output logic wd_reset_n,
  output logic wd_reset_req
);
  localparam int PW = `SWD_RST_PULSE_CYCLES;
  localparam int WW = $clog2(WAKE_CYCLES + 1);
  swd_pkg::swd_state_t state_r;
  logic watchdog_activate_r;
  logic [6:0] count_r;
  logic [WW-1:0] wake_cnt_r;
  logic [7:0] pulse_r;
  logic opt_s1_r;
  logic hw_opt_r;
  logic wake_s1_r;
  logic wake_s2_r;
  logic active;
  logic counting;
  logic tick;
  logic fire;

  // option pin passes two flops, held over reset release
  always_ff @(posedge clk) begin
    opt_s1_r <= hw_watchdog_option;
    hw_opt_r <= opt_s1_r;
  end

  // external wake pin passes two flops before the state machine
  always_ff @(posedge clk) begin
    wake_s1_r <= ext_wakeup;
    wake_s2_r <= wake_s1_r;
  end

  assign active = hw_opt_r || watchdog_activate_r;
  // wait mode intentionally not used in the gate
  assign counting = (state_r == swd_pkg::SWD_RUN);

  swd_divider #(
    .DIV(TICK_CYCLES)
  ) u_div (
    .clk(clk),
    .reset(reset),
    .run(counting),
    .tick(tick)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= swd_pkg::SWD_RUN;
      wake_cnt_r <= '0;
    end else begin
      case (state_r)
        swd_pkg::SWD_RUN: begin
          if (halt_enter) begin
            state_r <= swd_pkg::SWD_HALTED;
          end
        end
        swd_pkg::SWD_HALTED: begin
          if (wake_s2_r) begin
            state_r <= swd_pkg::SWD_WAKE;
            wake_cnt_r <= '0;
          end
        end
        swd_pkg::SWD_WAKE: begin
          if (wake_cnt_r == WW'(WAKE_CYCLES - 1)) begin
            state_r <= swd_pkg::SWD_RUN;
          end else begin
            wake_cnt_r <= wake_cnt_r + WW'(1);
          end
        end
        default: begin
          state_r <= swd_pkg::SWD_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      watchdog_activate_r <= 1'b0;
    end else if (ctrl_write && ctrl_wdata[`SWD_ACT_BIT]) begin
      watchdog_activate_r <= 1'b1;
    end
  end

  // a write wins over a same-cycle decrement
  always_ff @(posedge clk) begin
    if (reset) begin
      count_r <= 7'h7F;
    end else if (ctrl_write) begin
      count_r <= ctrl_wdata[6:0];
    end else if (tick) begin
      count_r <= count_r - 7'h01;
    end
  end

  assign watchdog_control = {watchdog_activate_r, count_r};

  always_comb begin
    fire = 1'b0;
    if (active && counting) begin
      if (tick && !ctrl_write && count_r == 7'h40) begin
        fire = 1'b1;
      end
    end
    if (ctrl_write && !ctrl_wdata[`SWD_TOP_BIT] && state_r == swd_pkg::SWD_RUN) begin
      if (hw_opt_r || watchdog_activate_r || ctrl_wdata[`SWD_ACT_BIT]) begin
        fire = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pulse_r <= 8'h00;
    end else if (fire && pulse_r == 8'h00) begin
      pulse_r <= 8'(PW);
    end else if (pulse_r != 8'h00) begin
      pulse_r <= pulse_r - 8'h01;
    end
  end

  assign wd_reset_n = (pulse_r == 8'h00);
  assign wd_reset_req = (pulse_r != 8'h00);
endmodule

// File: tb/swd_timer_asserts.sv
// checker for the supervisor timer
`timescale 1ns/100ps
module swd_timer_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic ctrl_write,
  input wire logic [7:0] ctrl_wdata,
  input wire logic [7:0] watchdog_control,
  input wire logic halt_enter,
  input wire logic ext_wakeup,
  input wire logic wd_reset_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [6:0] lc_r;
  logic hlt_r;
  always_ff @(posedge clk) lc_r <= wd_reset_n ? 7'h00 : lc_r + 7'h01;
  always_ff @(posedge clk) hlt_r <= !reset && (halt_enter || (hlt_r && !ext_wakeup));
  sequence s_last_tick;
    watchdog_control == 8'hC0 ##1 watchdog_control == 8'hBF;
  endsequence
  a_reset_value: assert property ($fell(reset) |-> watchdog_control == 8'h7F) else $error("bad reset");
  a_pulse_len: assert property ($rose(wd_reset_n) |-> lc_r == 7'h32) else $error("pulse width");
  a_timeout_fire: assert property (s_last_tick |-> ##[0:1] !wd_reset_n) else $error("no fire");
  a_act_sticky: assert property (watchdog_control[7] |=> watchdog_control[7]) else $error("act cleared");
  a_reload_take: assert property (ctrl_write && ctrl_wdata[7:6] == 2'b11 |=>
    watchdog_control == $past(ctrl_wdata)) else $error("reload lost");
  a_count_step: assert property (!$past(ctrl_write) && $changed(watchdog_control[6:0]) |->
    watchdog_control[6:0] == $past(watchdog_control[6:0]) - 7'h01) else $error("bad step");
  a_sw_reset: assert property (ctrl_write && ctrl_wdata[7:6] == 2'b10 && !hlt_r |=>
    ##[0:1] !wd_reset_n) else $error("no sw reset");
  a_halt_freeze: assert property (hlt_r |=> $stable(watchdog_control)) else $error("count in halt");
  a_wake_hold: assert property (hlt_r && ext_wakeup |=>
    $stable(watchdog_control)[*8]) else $error("early resume");
endmodule
bind swd_timer swd_timer_asserts swd_timer_asserts_i (.clk, .reset, .ctrl_write, .ctrl_wdata,
  .watchdog_control, .halt_enter, .ext_wakeup, .wd_reset_n);

// File: tb/swd_timer_tb.sv
// self-checking bench for the supervisor timer
`timescale 1ns/100ps
module swd_timer_tb;
  logic clk = 0, reset = 1, opt = 0, wr = 0, halt = 0, wake = 0;
  logic wt = 0;
  logic [7:0] wd = 8'h00, ctl, v;
  logic pin_n, req;
  int n_mismatch = 0, checks_done = 0, cyc = 0, k;
  always #5 clk = ~clk;
  swd_timer #(.TICK_CYCLES(16), .WAKE_CYCLES(8)) swd_timer_i (.clk, .reset, .hw_watchdog_option(opt),
    .ctrl_write(wr), .ctrl_wdata(wd), .watchdog_control(ctl), .halt_enter(halt), .ext_wakeup(wake),
    .wait_mode(wt), .wd_reset_n(pin_n), .wd_reset_req(req));
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_ctl(logic [7:0] d);
    @(negedge clk);
    wr = 1;
    wd = d;
    @(negedge clk);
    wr = 0;
  endtask
  task automatic rst(logic o);
    reset = 1;
    opt = o;
    repeat (10) @(negedge clk);
    reset = 0;
  endtask
  task automatic wait_low(int lim);
    for (k = 0; k < lim && pin_n; k++) @(negedge clk);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    if (++cyc > 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    rst(0);
    chk(ctl, 8'h7F);
    chk(pin_n, 1);
    chk(req, 0);
    wr_ctl(8'h41);
    wait_low(40);
    chk(pin_n, 1);
    chk(ctl[7:6], 8'h00);
    wt = 1;
    wr_ctl(8'hC1);
    chk(ctl, 8'hC1);
    wait_low(60);
    chk(ctl, 8'hBF);
    chk(k > 16 && k < 35, 1);
    for (k = 0; !pin_n && k < 60; k++) @(negedge clk);
    chk(k, 50);
    $display("timeout test done");
    wr_ctl(8'h7F);
    chk(ctl, 8'hFF);
    wr_ctl(8'h80);
    wait_low(3);
    chk(pin_n, 0);
    chk(req, 1);
    repeat (60) @(negedge clk);
    $display("deactivate test done");
    wr_ctl(8'hFF);
    v = ctl;
    while (ctl == v) @(negedge clk);
    v = ctl;
    halt = 1;
    @(negedge clk);
    halt = 0;
    repeat (100) @(negedge clk);
    chk(ctl, v);
    chk(pin_n, 1);
    wake = 1;
    @(negedge clk);
    wake = 0;
    for (k = 1; ctl == v && k < 40; k++) @(negedge clk);
    chk(k > 22 && k < 30, 1);
    $display("halt test done");
    rst(1);
    wait_low(1100);
    chk(pin_n, 0);
    chk(ctl[6:0], 7'h3F);
    $display("hardware mode test done");
    end_of_test();
  end
endmodule
